// File: core/capture_compare_defs.svh
`ifndef CAPTURE_COMPARE_DEFS_SVH
`define CAPTURE_COMPARE_DEFS_SVH

// ----------------------------------------------------------------
// register offsets on the plain register port
// ----------------------------------------------------------------
`define ADDR_CHANNEL_CONTROL 3'h0
`define ADDR_VALUE_LOW       3'h1
`define ADDR_VALUE_HIGH      3'h2
`define ADDR_PERIOD_LIMIT    3'h3
`define ADDR_TIMER_CONTROL   3'h4
`define ADDR_PERIOD_TIMER    3'h5
`define ADDR_EVENT_STATUS    3'h6

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_MODE_HI   3
`define CTRL_MODE_LO   0
`define CTRL_DUTY_HI   5
`define CTRL_DUTY_LO   4
`define TCTL_POST_HI   6
`define TCTL_POST_LO   3
`define TCTL_ON_BIT    2
`define TCTL_PS_HI     1
`define TCTL_PS_LO     0

// ----------------------------------------------------------------
// mode codes
// ----------------------------------------------------------------
`define MODE_OFF       4'h0
`define MODE_CMP_SET   4'h8
`define MODE_CMP_CLEAR 4'h9
`define MODE_CMP_SOFT  4'ha
`define MODE_CMP_TRIG  4'hb
`define MODE_GRP_CAP   2'h1
`define MODE_GRP_CMP   2'h2
`define MODE_GRP_PWM   2'h3

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define PERIOD_LIMIT_RESET 8'hff
`define DIV_LAST_PS1       6'h03
`define DIV_LAST_PS4       6'h0f
`define DIV_LAST_PS16      6'h3f
`define EDGE_LAST_4TH      4'h3
`define EDGE_LAST_16TH     4'hf

`endif

// File: core/capture_compare_pkg.sv
package capture_compare_pkg;

  // capture edge selection, low two bits of a capture mode code
  typedef enum logic [1:0] {
    EDGE_FALL    = 2'b00,
    EDGE_RISE    = 2'b01,
    EDGE_RISE4   = 2'b10,
    EDGE_RISE16  = 2'b11
  } edge_sel_t;

  // register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_bus_t;

  // edge prescaler state
  typedef struct packed {
    logic       sync_a;
    logic       sync_b;
    logic       prev;
    logic [3:0] count;
  } edge_state_t;

  // channel state
  typedef struct packed {
    logic [5:0] control;
    logic [7:0] value_low;
    logic [7:0] value_high;
    logic [1:0] duty_latch;
    logic [7:0] period_limit;
    logic [6:0] timer_control;
    logic [7:0] period_timer;
    logic [5:0] div_count;
    logic [3:0] post_count;
    logic       out_latch;
    logic       event_flag;
    logic       match_prev;
    logic [7:0] rd_data;
  } unit_state_t;

endpackage : capture_compare_pkg

// File: core/capture_compare_pwm_unit.sv
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "capture_compare_defs.svh"

// Operation
// RL1: software runs the timebase synchronously whenever capture or compare is used.
// RL2: software masks the channel interrupt and clears the flag after mode changes.
// RL3: edge prescaler counter clears when off, outside capture, and on reset.
// RL4: direct prescale switch keeps the counter; software writes zero first.
// RL5: compare matches 16-bit value to timebase, drives pin per mode, sets flag.
// RL6: writing zero to channel control forces the output latch low.
// RL7: software interrupt compare sets the flag and leaves the pin alone.
// RL8: special event on first channel pulses a timebase reset.
// RL9: second channel's special event also starts conversion when converter enabled.
// RL10: special event timebase reset never raises the overflow flag.
// RL11: PWM drives up to 10-bit pulses; software makes the pin an output.
// RL12: PWM period is (limit plus one) times four times prescale clocks.
// RL13: at limit the next tick clears timer, sets pin unless zero, latches duty.
// RL14: postscaler only paces the update pulse, never the PWM period.
// RL15: duty is value low byte above control bits five and four.
// RL16: duty writes take effect at period end; high byte read-only in PWM.
// RL17: active duty lives in the high byte plus a 2-bit latch.
// RL18: pin clears when active duty equals timer with two low divider bits.
// RL19: duty beyond the period never clears the pin.
// RL20: software sets period, duty, direction, timer, then selects PWM.
// RL21: period timer prescale divides by 1, 4 or 16.
// RL22: resolution equals log2 of oscillator over pulse frequency.
// RL23: mode codes: off, four captures, four compares, PWM on 11xx.
// RL24: capture copies the timebase and sets the flag; software clears it.
// RL25: pin is synchronised before edge detection.
module capture_compare_pwm_unit
  import capture_compare_pkg::*;
#(
  parameter bit IS_SECOND_CHANNEL = 1'b0,
  parameter int TIMEBASE_W        = 16
)(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire reg_bus_t    bus_req,
  output logic      [7:0]  rd_data,
  input  wire logic [15:0] capture_timebase,
  input  wire logic        timebase_carry,
  input  wire logic        adc_enabled,
  input  wire logic        port_direction,
  input  wire logic        channel_pin_in,
  output logic             channel_pin_out,
  output logic             channel_pin_oe,
  output logic             channel_event_flag,
  output logic             timebase_reset,
  output logic             adc_start,
  output logic             timebase_overflow_set,
  output logic             period_update_pulse
);

  if (TIMEBASE_W != 16) begin : g_width_check
    $error("capture_compare_pwm_unit serves only a 16-bit timebase");
  end

  unit_state_t state_reg;
  unit_state_t state_next;
  logic [3:0]  mode;
  logic        cap_mode;
  logic        cmp_mode;
  logic        pwm_mode;
  logic        cap_event;
  logic        cmp_match;
  logic        cmp_hit;
  logic        trig_hit;
  logic        timer_on;
  logic        tick;
  logic        roll;
  logic [9:0]  duty_new;
  logic [9:0]  duty_active;
  logic [9:0]  timer_ext;
  logic [7:0]  rd_mux;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // last divider count of one period timer tick: four clocks times prescale
  function automatic logic [5:0] div_last(input logic [1:0] ps);
    case (ps)
      2'b00:   div_last = `DIV_LAST_PS1;
      2'b01:   div_last = `DIV_LAST_PS4;
      default: div_last = `DIV_LAST_PS16;
    endcase
  endfunction : div_last

  // two divider bits that extend the timer below its count
  function automatic logic [1:0] low_bits(input logic [5:0] div, input logic [1:0] ps);
    case (ps)
      2'b00:   low_bits = div[1:0];
      2'b01:   low_bits = div[3:2];
      default: low_bits = div[5:4];
    endcase
  endfunction : low_bits

  // ----------------------------------------------------------------
  // capture edge prescaler
  // ----------------------------------------------------------------
  capture_edge_prescaler u_edge (
    .clk           (clk),
    .rst_b         (rst_b),
    .pin_in        (channel_pin_in),
    .clear         (!cap_mode),        // RL3 RL4
    .sel           (edge_sel_t'(mode[1:0])),
    .capture_event (cap_event)
  );

  // ----------------------------------------------------------------
  // decode and shared terms
  // ----------------------------------------------------------------
  always_comb begin
    mode        = state_reg.control[`CTRL_MODE_HI:`CTRL_MODE_LO];
    cap_mode    = (mode[3:2] == `MODE_GRP_CAP);                          // RL23
    cmp_mode    = (mode[3:2] == `MODE_GRP_CMP);
    pwm_mode    = (mode[3:2] == `MODE_GRP_PWM);
    cmp_match   = ({state_reg.value_high, state_reg.value_low} == capture_timebase); // RL5
    cmp_hit     = cmp_mode && cmp_match && !state_reg.match_prev;
    trig_hit    = cmp_hit && (mode == `MODE_CMP_TRIG);                   // RL8
    timer_on    = state_reg.timer_control[`TCTL_ON_BIT];
    tick        = timer_on && (state_reg.div_count ==
                  div_last(state_reg.timer_control[`TCTL_PS_HI:`TCTL_PS_LO])); // RL21
    roll        = tick && (state_reg.period_timer == state_reg.period_limit);
    duty_new    = {state_reg.value_low, state_reg.control[`CTRL_DUTY_HI:`CTRL_DUTY_LO]}; // RL15
    duty_active = {state_reg.value_high, state_reg.duty_latch};         // RL17
  end

  // read multiplexer, unmapped offsets read zero
  always_comb begin
    case (bus_req.addr)
      `ADDR_CHANNEL_CONTROL: rd_mux = {2'h0, state_reg.control};
      `ADDR_VALUE_LOW:       rd_mux = state_reg.value_low;
      `ADDR_VALUE_HIGH:      rd_mux = state_reg.value_high;
      `ADDR_PERIOD_LIMIT:    rd_mux = state_reg.period_limit;
      `ADDR_TIMER_CONTROL:   rd_mux = {1'b0, state_reg.timer_control};
      `ADDR_PERIOD_TIMER:    rd_mux = state_reg.period_timer;
      `ADDR_EVENT_STATUS:    rd_mux = {7'h00, state_reg.event_flag};
      default:               rd_mux = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next            = state_reg;
    state_next.match_prev = cmp_match;
    state_next.rd_data    = bus_req.rd ? rd_mux : 8'h00;

    // period timer with divider and postscaler
    if (timer_on) begin
      state_next.div_count = tick ? 6'h00 : state_reg.div_count + 6'h01; // RL12
    end
    if (tick) begin
      state_next.period_timer = state_reg.period_timer + 8'h01;
    end
    if (roll) begin
      state_next.period_timer = 8'h00;                                   // RL13
      if (state_reg.post_count == state_reg.timer_control[`TCTL_POST_HI:`TCTL_POST_LO]) begin
        state_next.post_count = 4'h0;                                    // RL14
      end else begin
        state_next.post_count = state_reg.post_count + 4'h1;
      end
    end

    // register writes from software
    if (bus_req.wr) begin
      case (bus_req.addr)
        `ADDR_CHANNEL_CONTROL: state_next.control = bus_req.wdata[5:0];
        `ADDR_VALUE_LOW:       state_next.value_low = bus_req.wdata;      // RL16
        `ADDR_VALUE_HIGH: begin
          if (!pwm_mode) begin
            state_next.value_high = bus_req.wdata;                       // RL16
          end
        end
        `ADDR_PERIOD_LIMIT:    state_next.period_limit = bus_req.wdata;
        `ADDR_TIMER_CONTROL:   state_next.timer_control = bus_req.wdata[6:0];
        `ADDR_PERIOD_TIMER:    state_next.period_timer = bus_req.wdata;
        `ADDR_EVENT_STATUS: begin
          if (!bus_req.wdata[0]) begin
            state_next.event_flag = 1'b0;                                // RL24
          end
        end
        default: ;
      endcase
    end

    // timer as it stands next cycle, so the latch is low in the matching cycle
    // full 10-bit compare gives log2(osc/pulse) bits of resolution at prescale 1 only, two bits fewer at 4 and four fewer at 16
    timer_ext = {state_next.period_timer,
                 low_bits(state_next.div_count, state_next.timer_control[`TCTL_PS_HI:`TCTL_PS_LO])}; // RL22

    // pwm duty double buffer and pin
    if (pwm_mode) begin
      if (roll) begin
        state_next.value_high = state_reg.value_low;                     // RL13
        state_next.duty_latch = state_reg.control[`CTRL_DUTY_HI:`CTRL_DUTY_LO];
        state_next.out_latch  = (duty_new != 10'h000);                   // RL13
      end else if (duty_active == timer_ext) begin
        state_next.out_latch  = 1'b0;                                    // RL18 RL19
      end
    end

    // capture takes the timebase, a later one overwrites
    if (cap_mode && cap_event) begin
      state_next.value_high = capture_timebase[15:8];                    // RL24
      state_next.value_low  = capture_timebase[7:0];
      state_next.event_flag = 1'b1;
    end

    // compare actions on a fresh match
    if (cmp_hit) begin
      state_next.event_flag = 1'b1;                                      // RL5 RL7
      case (mode)
        `MODE_CMP_SET:   state_next.out_latch = 1'b1;                    // RL5
        `MODE_CMP_CLEAR: state_next.out_latch = 1'b0;                    // RL5
        default: ;
      endcase
    end

    // clearing the control register drops the output latch
    if (bus_req.wr && bus_req.addr == `ADDR_CHANNEL_CONTROL &&
        bus_req.wdata[3:0] == `MODE_OFF) begin
      state_next.out_latch = 1'b0;                                       // RL6
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg              <= '0;
      state_reg.period_limit <= `PERIOD_LIMIT_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rd_data               = state_reg.rd_data;
  assign channel_pin_out       = state_reg.out_latch;                    // RL11
  assign channel_pin_oe        = !port_direction;                        // RL11
  assign channel_event_flag    = state_reg.event_flag;
  assign timebase_reset        = trig_hit;                               // RL8 RL9
  assign adc_start             = trig_hit && IS_SECOND_CHANNEL && adc_enabled; // RL9
  assign timebase_overflow_set = timebase_carry && !trig_hit;            // RL10
  assign period_update_pulse   = roll &&
    (state_reg.post_count == state_reg.timer_control[`TCTL_POST_HI:`TCTL_POST_LO]); // RL14

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic [9:0] cyc_since;
  logic       cfg_quiet;
  logic       seen_roll;

  // period length observer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc_since <= 10'h000;
      cfg_quiet <= 1'b0;
      seen_roll <= 1'b0;
    end else begin
      cyc_since <= roll ? 10'h000 : cyc_since + 10'h001;
      seen_roll <= seen_roll | roll;
      cfg_quiet <= roll ? 1'b1 : (cfg_quiet && !bus_req.wr);
    end
  end

  sequence s_period_end;
    pwm_mode && roll;
  endsequence

  sequence s_new_period;
    state_reg.period_timer == 8'h00 && state_reg.value_high == $past(state_reg.value_low);
  endsequence

  a_capture_loads_value: assert property (cap_mode && cap_event && !bus_req.wr |=> // RL24
    {state_reg.value_high, state_reg.value_low} == $past(capture_timebase) && state_reg.event_flag)
    else $error("capture did not load timebase and flag");
  a_compare_set_pin: assert property (cmp_hit && mode == `MODE_CMP_SET && !bus_req.wr |=> // RL5
    channel_pin_out && channel_event_flag)
    else $error("compare set mode did not raise pin");
  a_compare_clear_pin: assert property (cmp_hit && mode == `MODE_CMP_CLEAR && !bus_req.wr |=> // RL5
    !channel_pin_out && channel_event_flag)
    else $error("compare clear mode did not drop pin");
  a_soft_int_pin: assert property (cmp_hit && mode == `MODE_CMP_SOFT && !bus_req.wr |=> // RL7
    $stable(channel_pin_out) && channel_event_flag)
    else $error("software interrupt compare touched the pin");
  a_trigger_resets_base: assert property (cmp_hit && mode == `MODE_CMP_TRIG |-> // RL8
    timebase_reset && !$past(timebase_reset))
    else $error("special event missed timebase reset");
  a_adc_start_gate: assert property (adc_start |-> // RL9
    timebase_reset && adc_enabled && IS_SECOND_CHANNEL)
    else $error("conversion start without its conditions");
  a_no_overflow_trig: assert property (timebase_reset |-> !timebase_overflow_set) // RL10
    else $error("special event raised overflow flag");
  a_ctrl_zero_clears: assert property (bus_req.wr && bus_req.addr == `ADDR_CHANNEL_CONTROL && // RL6
    bus_req.wdata == 8'h00 |=> !channel_pin_out [*2])
    else $error("control clear left output latch high");
  a_period_rollover: assert property (s_period_end |=> s_new_period) // RL13
    else $error("period end did not clear timer and latch duty");
  a_pwm_period_len: assert property (roll && seen_roll && cfg_quiet |-> // RL12
    cyc_since == 10'((state_reg.period_limit + 10'h001) *
    (10'(div_last(state_reg.timer_control[`TCTL_PS_HI:`TCTL_PS_LO])) + 10'h001) - 10'h001))
    else $error("pwm period length wrong");
  a_high_read_only: assert property (pwm_mode && bus_req.wr && bus_req.addr == `ADDR_VALUE_HIGH && // RL16
    !roll |=> $stable(state_reg.value_high))
    else $error("high byte written in pwm mode");

endmodule : capture_compare_pwm_unit
`default_nettype wire

// File: core/capture_edge_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "capture_compare_defs.svh"

module capture_edge_prescaler
  import capture_compare_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst_b,
  input  wire logic      pin_in,
  input  wire logic      clear,
  input  wire edge_sel_t sel,
  output logic           capture_event
);

  edge_state_t state_reg;
  edge_state_t state_next;
  logic        rise;
  logic        fall;

  // ----------------------------------------------------------------
  // synchroniser, edge detect and edge counter
  // ----------------------------------------------------------------
  always_comb begin
    state_next        = state_reg;
    state_next.sync_a = pin_in;               // RL25
    state_next.sync_b = state_reg.sync_a;
    state_next.prev   = state_reg.sync_b;
    rise              = state_reg.sync_b & ~state_reg.prev;
    fall              = ~state_reg.sync_b & state_reg.prev;
    capture_event     = 1'b0;
    case (sel)
      EDGE_FALL:   capture_event = fall;
      EDGE_RISE:   capture_event = rise;
      EDGE_RISE4:  capture_event = rise && (state_reg.count[1:0] == 2'(`EDGE_LAST_4TH));
      EDGE_RISE16: capture_event = rise && (state_reg.count == `EDGE_LAST_16TH);
      default:     capture_event = 1'b0;
    endcase
    if (rise) begin
      state_next.count = state_reg.count + 4'h1;
    end
    if (capture_event) begin
      state_next.count = 4'h0;
    end
    if (clear) begin
      state_next.count = 4'h0;                // RL3
    end
  end

  // state register, counter cleared by reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '0;                        // RL3
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : capture_edge_prescaler
`default_nettype wire

// File: tb/pin_partner_model.sv
`timescale 1ns/1ps
`default_nettype none

module pin_partner_model (
  input  wire logic clk,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      pin_level
);
  logic src_level;

  // ----------------------------------------
  // outside signal source
  // ----------------------------------------
  initial src_level = 1'b0;

  // source changes just after a clock edge
  task automatic drive(input logic lvl);
    @(posedge clk);
    src_level <= lvl;
  endtask : drive

  // the unit owns the wire while enabled, the source otherwise
  assign pin_level = pin_oe ? pin_out : src_level;
endmodule : pin_partner_model
`default_nettype wire

// File: tb/tb_capture_compare_pwm_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "capture_compare_defs.svh"

module tb_capture_compare_pwm_unit
  import capture_compare_pkg::*;
;
  logic        clk;
  logic        rst_b;
  reg_bus_t    bus_req;
  logic [7:0]  rd_data;
  logic [15:0] capture_timebase;
  logic        timebase_carry;
  logic        adc_enabled;
  logic        port_direction;
  logic        pin_level;
  logic        channel_pin_out;
  logic        channel_pin_oe;
  logic        channel_event_flag;
  logic        timebase_reset;
  logic        adc_start;
  logic        timebase_overflow_set;
  logic        period_update_pulse;
  logic        adc_start_b;
  int          miscompares;
  int          checked;
  logic [3:0]  cmp_mode [7] = '{4'h8, 4'ha, 4'hb, 4'h9, 4'ha, 4'h8, 4'hb};
  logic        cmp_pin  [7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};

  capture_compare_pwm_unit u_capture_compare_pwm_unit (
    .clk                   (clk),
    .rst_b                 (rst_b),
    .bus_req               (bus_req),
    .rd_data               (rd_data),
    .capture_timebase      (capture_timebase),
    .timebase_carry        (timebase_carry),
    .adc_enabled           (adc_enabled),
    .port_direction        (port_direction),
    .channel_pin_in        (pin_level),
    .channel_pin_out       (channel_pin_out),
    .channel_pin_oe        (channel_pin_oe),
    .channel_event_flag    (channel_event_flag),
    .timebase_reset        (timebase_reset),
    .adc_start             (adc_start),
    .timebase_overflow_set (timebase_overflow_set),
    .period_update_pulse   (period_update_pulse)
  );

  // second channel on the same bus, watched for its conversion start
  capture_compare_pwm_unit #(.IS_SECOND_CHANNEL(1'b1)) u_capture_compare_pwm_unit_b (
    .clk                   (clk),
    .rst_b                 (rst_b),
    .bus_req               (bus_req),
    .rd_data               (),
    .capture_timebase      (capture_timebase),
    .timebase_carry        (timebase_carry),
    .adc_enabled           (adc_enabled),
    .port_direction        (port_direction),
    .channel_pin_in        (pin_level),
    .channel_pin_out       (),
    .channel_pin_oe        (),
    .channel_event_flag    (),
    .timebase_reset        (),
    .adc_start             (adc_start_b),
    .timebase_overflow_set (),
    .period_update_pulse   ()
  );

  pin_partner_model u_pin_partner_model (
    .clk       (clk),
    .pin_out   (channel_pin_out),
    .pin_oe    (channel_pin_oe),
    .pin_level (pin_level)
  );

  // ----------------------------------------
  // clock and helpers
  // ----------------------------------------
  // 25 mhz system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic print_verdict;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    @(negedge clk);
    chk({8'h00, rd_data}, {8'h00, exp});
  endtask : rd

  // n rising edges, each held five clocks high then five low
  task automatic rises(input int n);
    repeat (n) begin
      u_pin_partner_model.drive(1'b1);
      repeat (4) @(posedge clk);
      u_pin_partner_model.drive(1'b0);
      repeat (4) @(posedge clk);
    end
  endtask : rises

  // pwm with period limit 1: run two periods, then count over four
  task automatic pwm_run(input logic [1:0] ps, input logic [7:0] vlow, input logic [1:0] dl, input int high_exp);
    int period;
    int hi;
    int pu;
    period = (ps == 2'h0) ? 8 : ((ps == 2'h1) ? 32 : 128);
    wr(`ADDR_CHANNEL_CONTROL, 8'h00);
    wr(`ADDR_PERIOD_LIMIT, 8'h01);
    wr(`ADDR_VALUE_LOW, vlow);
    wr(`ADDR_CHANNEL_CONTROL, {2'b00, dl, 4'h0});
    wr(`ADDR_TIMER_CONTROL, {1'b0, 4'h1, 1'b1, ps});
    wr(`ADDR_CHANNEL_CONTROL, {2'b00, dl, 4'hc});
    // extra clocks let a divider left high by a slower prescale wrap
    repeat (2 * period + 64) @(posedge clk);
    hi = 0;
    pu = 0;
    repeat (4 * period) begin
      @(negedge clk);
      hi += (channel_pin_out === 1'b1) ? 1 : 0;
      pu += (period_update_pulse === 1'b1) ? 1 : 0;
    end
    chk(16'(hi), 16'(4 * high_exp));
    chk(16'(pu), 16'h0002);
    chk({15'h0000, channel_pin_oe}, 16'h0001);
  endtask : pwm_run

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  // cuts a hang short, well beyond the expected run of about 3800 clocks
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 16'h0000, 16'h0001);
    print_verdict();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    miscompares      = 0;
    checked          = 0;
    rst_b            = 1'b0;
    bus_req          = '0;
    capture_timebase = 16'h0000;
    timebase_carry   = 1'b0;
    adc_enabled      = 1'b1;
    port_direction   = 1'b1;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    // reset values, unused bits and an unmapped place
    rd(`ADDR_CHANNEL_CONTROL, 8'h00);
    rd(`ADDR_PERIOD_LIMIT, 8'hff);
    rd(`ADDR_TIMER_CONTROL, 8'h00);
    rd(`ADDR_PERIOD_TIMER, 8'h00);
    rd(`ADDR_EVENT_STATUS, 8'h00);
    rd(3'h7, 8'h00);
    wr(`ADDR_CHANNEL_CONTROL, 8'hc0);
    rd(`ADDR_CHANNEL_CONTROL, 8'h00);
    wr(`ADDR_TIMER_CONTROL, 8'hf8);
    rd(`ADDR_TIMER_CONTROL, 8'h78);
    wr(`ADDR_TIMER_CONTROL, 8'h00);
    // capture on a rising edge
    @(posedge clk);
    capture_timebase <= 16'h5a3c;
    wr(`ADDR_CHANNEL_CONTROL, 8'h05);
    wr(`ADDR_EVENT_STATUS, 8'h00);
    rises(1);
    chk({15'h0000, channel_event_flag}, 16'h0001);
    rd(`ADDR_VALUE_LOW, 8'h3c);
    rd(`ADDR_VALUE_HIGH, 8'h5a);
    wr(`ADDR_EVENT_STATUS, 8'h00);
    rd(`ADDR_EVENT_STATUS, 8'h00);
    // capture on a falling edge only
    wr(`ADDR_CHANNEL_CONTROL, 8'h00);
    wr(`ADDR_CHANNEL_CONTROL, 8'h04);
    wr(`ADDR_EVENT_STATUS, 8'h00);
    u_pin_partner_model.drive(1'b1);
    repeat (8) @(posedge clk);
    chk({15'h0000, channel_event_flag}, 16'h0000);
    u_pin_partner_model.drive(1'b0);
    repeat (8) @(posedge clk);
    chk({15'h0000, channel_event_flag}, 16'h0001);
    // leave the prescaler part-way, then each prescaled mode from zero
    wr(`ADDR_CHANNEL_CONTROL, 8'h07);
    rises(2);
    for (int i = 0; i < 2; i++) begin
      wr(`ADDR_CHANNEL_CONTROL, 8'h00);
      wr(`ADDR_CHANNEL_CONTROL, (i == 0) ? 8'h06 : 8'h07);
      wr(`ADDR_EVENT_STATUS, 8'h00);
      rises((i == 0) ? 3 : 15);
      chk({15'h0000, channel_event_flag}, 16'h0000);
      rises(1);
      chk({15'h0000, channel_event_flag}, 16'h0001);
    end
    // compare modes against a moving timebase
    wr(`ADDR_CHANNEL_CONTROL, 8'h00);
    port_direction <= 1'b0;
    @(posedge clk);
    capture_timebase <= 16'h0000;
    wr(`ADDR_VALUE_LOW, 8'h34);
    wr(`ADDR_VALUE_HIGH, 8'h12);
    for (int i = 0; i < 7; i++) begin
      wr(`ADDR_CHANNEL_CONTROL, {4'h0, cmp_mode[i]});
      wr(`ADDR_EVENT_STATUS, 8'h00);
      @(posedge clk);
      capture_timebase <= 16'h1234;
      timebase_carry   <= 1'b1;
      adc_enabled      <= (i > 3);
      @(negedge clk);
      chk({15'h0000, timebase_reset}, {15'h0000, cmp_mode[i] == 4'hb});
      chk({15'h0000, adc_start}, 16'h0000);
      chk({15'h0000, adc_start_b}, {15'h0000, cmp_mode[i] == 4'hb && i > 3});
      chk({15'h0000, timebase_overflow_set}, {15'h0000, cmp_mode[i] != 4'hb});
      @(posedge clk);
      capture_timebase <= 16'h0000;
      timebase_carry   <= 1'b0;
      @(negedge clk);
      chk({15'h0000, channel_pin_out}, {15'h0000, cmp_pin[i]});
      chk({15'h0000, channel_event_flag}, 16'h0001);
    end
    wr(`ADDR_CHANNEL_CONTROL, 8'h00);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({15'h0000, channel_pin_out}, 16'h0000);
    // pwm over every prescale code, zero duty and duty beyond the period
    pwm_run(2'h0, 8'h01, 2'h1, 5);
    pwm_run(2'h1, 8'h01, 2'h1, 20);
    pwm_run(2'h2, 8'h01, 2'h1, 80);
    pwm_run(2'h3, 8'h01, 2'h1, 80);
    pwm_run(2'h0, 8'h00, 2'h0, 0);
    pwm_run(2'h0, 8'hff, 2'h3, 8);
    // high byte is read-only and takes the duty only at period end
    wr(`ADDR_VALUE_HIGH, 8'h77);
    rd(`ADDR_VALUE_HIGH, 8'hff);
    wr(`ADDR_PERIOD_LIMIT, 8'hff);
    wr(`ADDR_VALUE_LOW, 8'h00);
    rd(`ADDR_VALUE_HIGH, 8'hff);
    repeat (1100) @(posedge clk);
    rd(`ADDR_VALUE_HIGH, 8'h00);
    print_verdict();
  end
endmodule : tb_capture_compare_pwm_unit
`default_nettype wire
